/* File: slr_defs.svh */
// Offsets, field positions, reset values and counts of the stop-exit block.
// Assumes a 32-bit AXI4-Lite register space, word aligned.
`ifndef SLR_DEFS_SVH
`define SLR_DEFS_SVH
`define SLR_OFS_CONTROL 12'h000
`define SLR_OFS_STATUS 12'h004
`define SLR_OFS_SLOW 12'h008
`define SLR_BIT_NO_LIMP_HOME 0
`define SLR_BIT_MON_ENABLE 1
`define SLR_BIT_FORCED_MON 2
`define SLR_BIT_WAKE_DELAY 3
`define SLR_BIT_PSEUDO_STOP 4
`define SLR_BIT_IRQ_ENABLE 5
`define SLR_BIT_AUTO_BW 6
`define SLR_BIT_BUS_PLL_SEL 7
`define SLR_BIT_MOD_CLK_SEL 8
`define SLR_CONTROL_WIDTH 9
`define SLR_BIT_LIMP_STATUS 0
`define SLR_BIT_IRQ_FLAG 1
`define SLR_BIT_STOPPED 2
`define SLR_BIT_PSEUDO 3
`define SLR_CONTROL_RESET 9'h042
`define SLR_SLOW_RESET 6'h00
`define SLR_CHECK_COUNT 4096
`define SLR_SHORT_COUNT 16
`define SLR_RESP_OKAY 2'h0
`define SLR_RESP_SLVERR 2'h2
`endif

/* File: slr_pkg.sv */
// Types of the stop-exit and limp-home recovery block.
// Assumes the constants header is compiled alongside.
package slr_pkg;
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_STOP = 3'b001,
    ST_LIMP_HOLD = 3'b010,
    ST_LIMP_RUN = 3'b011,
    ST_XTAL_WAIT = 3'b100,
    ST_XTAL_DELAY = 3'b101
  } slr_state_type;
endpackage : slr_pkg

/* File: slr_stop_recovery.sv */
// Stop and pseudo-stop exit sequencer with limp-home recovery and AXI4-Lite registers.
// Assumes one 100 MHz clock aclk; wake pins and monitor status arrive asynchronously.
//
// Summary of operation
// - Stop exit with delay zero is fast
// - No limp-home zero: mask monitor, wake limp
// - Fast recovery without crystal runs software on limp clock
// - Limp mode checks monitor at 4096, every 8192
// - Clock found: leave limp, clear status, set flag
// - Leaving limp restores bus and module selects
// - Auto plus PLL select: relock after exit
// - Square wave, delay zero: no status flag
// - Pseudo-stop enable keeps oscillator at reduced amplitude
// - Wake on reset, IRQs, key ports, CAN
// - Pseudo exit delayed: limp, VCO counter, forced selects
// - After 4096 check: crystal exit or limp flagged
// - No limp-home with monitor: stop gives monitor reset
// - No limp-home, no monitor: crystal-only recovery
// - That case with delay: 4096 cycles then crystal
// - That case without delay: 16 cycles then crystal
// - Pseudo exit undelayed behaves as fast recovery
// - Pseudo recovery on limp clock restarts VCO
// - Delay counts counter clocks set by slow divider
// - Delay one gives 4096 count; zero gives none with limp-home, 16 without
// - Interrupt requested only when enable set
// - Flag cleared by writing one
`timescale 1ns/100ps
`include "slr_defs.svh"

module slr_stop_recovery #(
  parameter int check_count = `SLR_CHECK_COUNT
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic stop_exec,
  input wire logic wake_ext_reset,
  input wire logic wake_irq,
  input wire logic wake_nonmaskable_irq,
  input wire logic wake_key_port_j,
  input wire logic wake_key_port_h,
  input wire logic wake_can_controller,
  input wire logic crystal_present,
  output logic cpu_run,
  output logic stop_hold,
  output logic osc_reduced_amplitude,
  output logic counter_from_vco,
  output logic bus_clock_pll_select_out,
  output logic module_clock_select_out,
  output logic monitor_enable_out,
  output logic monitor_reset_req,
  output logic vco_restart,
  output logic pll_relock_req,
  output logic limp_home_irq
);

  localparam logic [12:0] term_val = 13'(check_count - 1);
  localparam logic [12:0] wrap_val = 13'(2 * check_count - 1);
  localparam logic [12:0] short_val = 13'(`SLR_SHORT_COUNT - 1);

  slr_pkg::slr_state_type state;
  logic [`SLR_CONTROL_WIDTH-1:0] control;
  logic [5:0] slow_divider;
  logic limp_home_status;
  logic limp_home_irq_flag;
  logic pseudo_mode;
  logic [6:0] sync_a;
  logic [6:0] sync_b;
  logic wake_any;
  logic xtal_ok;
  logic [7:0] div_cnt;
  logic [7:0] div_last;
  logic tick;
  logic [12:0] rec_cnt;
  logic restart_cnt;
  logic term_hit;
  logic short_hit;
  logic check_present;
  logic check_valid;
  logic set_flag;
  logic aw_held;
  logic w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic clear_flag;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  wire no_limp_home = control[`SLR_BIT_NO_LIMP_HOME];
  wire monitor_on = control[`SLR_BIT_MON_ENABLE] | control[`SLR_BIT_FORCED_MON];
  wire wake_delay_select = control[`SLR_BIT_WAKE_DELAY];
  wire in_limp = (state == slr_pkg::ST_LIMP_HOLD) | (state == slr_pkg::ST_LIMP_RUN);

  // Two-stage synchronisers for wake pins and monitor status
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync_a <= 7'h00;
      sync_b <= 7'h00;
    end
    else
    begin
      sync_a <= {crystal_present, wake_can_controller, wake_key_port_h, wake_key_port_j,
                 wake_nonmaskable_irq, wake_irq, wake_ext_reset};
      sync_b <= sync_a;
    end
  end

  // Any of the six wake sources
  assign wake_any = |sync_b[5:0];
  assign xtal_ok = sync_b[6];

  // Counter clock from slow divider: two aclk at zero, else four per step
  assign div_last = (slow_divider == 6'h00) ? 8'h01 : 8'({slow_divider, 2'b00} - 8'h01);
  assign tick = (div_cnt >= div_last);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      div_cnt <= 8'h00;
    else if (tick)
      div_cnt <= 8'h00;
    else
      div_cnt <= div_cnt + 8'h01;
  end

  // Free-running recovery counter, restarted on wake
  assign term_hit = tick & (rec_cnt == term_val);
  assign short_hit = tick & (rec_cnt == short_val);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rec_cnt <= 13'h0000;
    else if (restart_cnt)
      rec_cnt <= 13'h0000;
    else if (tick)
      rec_cnt <= (rec_cnt == wrap_val) ? 13'h0000 : rec_cnt + 13'h0001;
  end

  // Monitor status captured at the terminal count
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      check_present <= 1'b0;
      check_valid <= 1'b0;
    end
    else
    begin
      check_present <= xtal_ok;
      check_valid <= term_hit & in_limp;
    end
  end

  // Counter restart on every wake from stop
  assign restart_cnt = (state == slr_pkg::ST_STOP) & wake_any;

  // Main stop-exit sequencer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= slr_pkg::ST_RUN;
      pseudo_mode <= 1'b0;
      limp_home_status <= 1'b0;
      set_flag <= 1'b0;
      monitor_reset_req <= 1'b0;
      vco_restart <= 1'b0;
      pll_relock_req <= 1'b0;
    end
    else
    begin
      set_flag <= 1'b0;
      monitor_reset_req <= 1'b0;
      vco_restart <= 1'b0;
      pll_relock_req <= 1'b0;
      case (state)
        slr_pkg::ST_RUN:
        begin
          if (stop_exec)
          begin
            if (no_limp_home & monitor_on)
              monitor_reset_req <= 1'b1;
            else
            begin
              state <= slr_pkg::ST_STOP;
              pseudo_mode <= control[`SLR_BIT_PSEUDO_STOP];
            end
          end
        end
        slr_pkg::ST_STOP:
        begin
          if (wake_any)
          begin
            if (no_limp_home)
              state <= slr_pkg::ST_XTAL_WAIT;
            else if (wake_delay_select)
            begin
              state <= slr_pkg::ST_LIMP_HOLD;
              vco_restart <= pseudo_mode;
            end
            else if (xtal_ok)
              state <= slr_pkg::ST_RUN;
            else
            begin
              state <= slr_pkg::ST_LIMP_RUN;
              limp_home_status <= 1'b1;
              set_flag <= 1'b1;
              vco_restart <= pseudo_mode;
            end
          end
        end
        slr_pkg::ST_LIMP_HOLD:
        begin
          if (check_valid)
          begin
            if (check_present)
            begin
              state <= slr_pkg::ST_RUN;
              pll_relock_req <= control[`SLR_BIT_AUTO_BW] & control[`SLR_BIT_BUS_PLL_SEL];
            end
            else
            begin
              state <= slr_pkg::ST_LIMP_RUN;
              limp_home_status <= 1'b1;
              set_flag <= 1'b1;
            end
          end
        end
        slr_pkg::ST_LIMP_RUN:
        begin
          if (check_valid & check_present)
          begin
            state <= slr_pkg::ST_RUN;
            limp_home_status <= 1'b0;
            set_flag <= 1'b1;
            pll_relock_req <= control[`SLR_BIT_AUTO_BW] & control[`SLR_BIT_BUS_PLL_SEL];
          end
        end
        slr_pkg::ST_XTAL_WAIT:
        begin
          if (xtal_ok)
            state <= slr_pkg::ST_XTAL_DELAY;
        end
        slr_pkg::ST_XTAL_DELAY:
        begin
          if (wake_delay_select ? term_hit : short_hit)
            state <= slr_pkg::ST_RUN;
        end
        default:
          state <= slr_pkg::ST_RUN;
      endcase
    end
  end

  // Registered clock and run outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cpu_run <= 1'b1;
      stop_hold <= 1'b0;
      osc_reduced_amplitude <= 1'b0;
      counter_from_vco <= 1'b0;
      bus_clock_pll_select_out <= 1'b0;
      module_clock_select_out <= 1'b0;
      monitor_enable_out <= 1'b0;
    end
    else
    begin
      cpu_run <= (state == slr_pkg::ST_RUN) | (state == slr_pkg::ST_LIMP_RUN);
      stop_hold <= ~((state == slr_pkg::ST_RUN) | (state == slr_pkg::ST_LIMP_RUN));
      osc_reduced_amplitude <= (state == slr_pkg::ST_STOP) & pseudo_mode;
      counter_from_vco <= in_limp;
      // Forced selects in limp, latched values otherwise
      bus_clock_pll_select_out <= in_limp | control[`SLR_BIT_BUS_PLL_SEL];
      module_clock_select_out <= ~in_limp & control[`SLR_BIT_MOD_CLK_SEL];
      // Monitor masked in stop, asserted in limp
      if (in_limp)
        monitor_enable_out <= 1'b1;
      else if ((state != slr_pkg::ST_RUN) & ~no_limp_home)
        monitor_enable_out <= 1'b0;
      else
        monitor_enable_out <= monitor_on;
    end
  end

  // Interrupt flag: hardware set beats write-one clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      limp_home_irq_flag <= 1'b0;
    else if (set_flag)
      limp_home_irq_flag <= 1'b1;
    else if (clear_flag)
      limp_home_irq_flag <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      limp_home_irq <= 1'b0;
    else
      limp_home_irq <= limp_home_irq_flag & control[`SLR_BIT_IRQ_ENABLE];
  end

  // AXI write address and data capture, either order
  assign s_axi_awready = ~aw_held;
  assign s_axi_wready = ~w_held;
  assign do_write = aw_held & w_held & ~s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid & ~aw_held)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (do_write)
        aw_held <= 1'b0;
      if (s_axi_wvalid & ~w_held)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (do_write)
        w_held <= 1'b0;
    end
  end

  assign clear_flag = do_write & (aw_addr == `SLR_OFS_STATUS) & w_strb[0]
                      & w_data[`SLR_BIT_IRQ_FLAG];

  // Register writes and write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      control <= `SLR_CONTROL_RESET;
      slow_divider <= `SLR_SLOW_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SLR_RESP_OKAY;
    end
    else
    begin
      if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `SLR_RESP_OKAY;
        case (aw_addr)
          `SLR_OFS_CONTROL:
          begin
            if (w_strb[0])
              control[7:0] <= w_data[7:0];
            if (w_strb[1])
              control[8] <= w_data[8];
          end
          `SLR_OFS_SLOW:
          begin
            if (w_strb[0])
              slow_divider <= w_data[5:0];
          end
          `SLR_OFS_STATUS:
            s_axi_bresp <= `SLR_RESP_OKAY;
          default:
            s_axi_bresp <= `SLR_RESP_SLVERR;
        endcase
      end
    end
  end

  // Read data selection
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    next_rresp = `SLR_RESP_OKAY;
    case (s_axi_araddr)
      `SLR_OFS_CONTROL:
        next_rdata[`SLR_CONTROL_WIDTH-1:0] = control;
      `SLR_OFS_STATUS:
      begin
        next_rdata[`SLR_BIT_LIMP_STATUS] = limp_home_status;
        next_rdata[`SLR_BIT_IRQ_FLAG] = limp_home_irq_flag;
        next_rdata[`SLR_BIT_STOPPED] = ~cpu_run;
        next_rdata[`SLR_BIT_PSEUDO] = pseudo_mode;
      end
      `SLR_OFS_SLOW:
        next_rdata[5:0] = slow_divider;
      default:
        next_rresp = `SLR_RESP_SLVERR;
    endcase
  end

  // Read channel
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SLR_RESP_OKAY;
    end
    else if (s_axi_arvalid & ~s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule : slr_stop_recovery

/* File: slr_stop_props.sv */
// Assertions on the recovery outputs of the stop-exit sequencer.
// Assumes binding to the sequencer top; one clock, synchronous active-low reset.
`timescale 1ns/100ps

module slr_stop_props #(
  parameter int check_count = 4096
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic stop_exec,
  input wire logic cpu_run,
  input wire logic stop_hold,
  input wire logic osc_reduced_amplitude,
  input wire logic counter_from_vco,
  input wire logic bus_clock_pll_select_out,
  input wire logic module_clock_select_out,
  input wire logic monitor_enable_out,
  input wire logic monitor_reset_req,
  input wire logic vco_restart,
  input wire logic pll_relock_req
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  run_hold_excl_a: assert property (cpu_run != stop_hold)
    else $error("run and hold overlap");
  limp_selects_a: assert property (counter_from_vco |-> bus_clock_pll_select_out
    && !module_clock_select_out)
    else $error("limp selects not forced");
  limp_monitor_a: assert property (counter_from_vco |-> monitor_enable_out)
    else $error("monitor off in limp");
  pseudo_stopped_a: assert property (osc_reduced_amplitude |-> stop_hold
    && !counter_from_vco)
    else $error("reduced amplitude outside stop");
  monrst_pulse_a: assert property (monitor_reset_req |=> !monitor_reset_req)
    else $error("monitor reset too long");
  vco_start_a: assert property (vco_restart |-> ##[0:2] counter_from_vco)
    else $error("restart without limp clock");
  relock_exit_a: assert property (pll_relock_req |-> ##[0:1] (!counter_from_vco
    && cpu_run && bus_clock_pll_select_out))
    else $error("relock outside limp exit");
  stop_entry_a: assert property (stop_exec && cpu_run && !counter_from_vco
    |-> ##[1:3] (stop_hold || monitor_reset_req))
    else $error("stop not taken");
  limp_leave_a: assert property ($fell(counter_from_vco) |-> cpu_run)
    else $error("limp left without run");

  // Main recovery paths reached
  cover property (vco_restart);
  cover property (pll_relock_req);
  cover property (monitor_reset_req);
endmodule : slr_stop_props

bind slr_stop_recovery slr_stop_props #(.check_count(check_count)) props (
  .aclk(aclk), .aresetn(aresetn), .stop_exec(stop_exec), .cpu_run(cpu_run),
  .stop_hold(stop_hold), .osc_reduced_amplitude(osc_reduced_amplitude),
  .counter_from_vco(counter_from_vco), .bus_clock_pll_select_out(bus_clock_pll_select_out),
  .module_clock_select_out(module_clock_select_out),
  .monitor_enable_out(monitor_enable_out), .monitor_reset_req(monitor_reset_req),
  .vco_restart(vco_restart), .pll_relock_req(pll_relock_req));

/* File: slr_osc_wake_model.sv */
// Model of the external oscillator and of the wake sources.
// Assumes the bench switches the oscillator and picks one wake source at a time.
`timescale 1ns/100ps

module slr_osc_wake_model #(
  parameter int startup = 40
) (
  input wire logic aclk,
  input wire logic osc_enable,
  input wire logic wake_go,
  input wire logic [2:0] wake_sel,
  output logic crystal_present,
  output logic wake_ext_reset,
  output logic wake_irq,
  output logic wake_nonmaskable_irq,
  output logic wake_key_port_j,
  output logic wake_key_port_h,
  output logic wake_can_controller
);
  int run_cnt = 0;
  int rst_cnt = 0;

  // Clock reported only after start-up; lost at once
  always @(posedge aclk)
  begin
    if (!osc_enable)
      run_cnt <= 0;
    else if (run_cnt < startup)
      run_cnt <= run_cnt + 1;
  end
  assign crystal_present = run_cnt >= startup;

  // Reset wake held past the start-up time
  always @(posedge aclk)
  begin
    if (wake_go && wake_sel == 3'h0)
      rst_cnt <= startup;
    else if (rst_cnt > 0)
      rst_cnt <= rst_cnt - 1;
  end
  assign wake_ext_reset = (wake_go && wake_sel == 3'h0) || rst_cnt > 0;
  assign wake_irq = wake_go && wake_sel == 3'h1;
  assign wake_nonmaskable_irq = wake_go && wake_sel == 3'h2;
  assign wake_key_port_j = wake_go && wake_sel == 3'h3;
  assign wake_key_port_h = wake_go && wake_sel == 3'h4;
  assign wake_can_controller = wake_go && wake_sel == 3'h5;
endmodule : slr_osc_wake_model

/* File: slr_stop_recovery_bench.sv */
// Bench for the stop-exit sequencer: register tasks and recovery sequences.
// Assumes the oscillator model drives the clock status and the wake lines.
`timescale 1ns/100ps
`include "slr_defs.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end

module slr_stop_recovery_bench;
  localparam int chk = 32;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic stop_exec = 1'b0, osc_enable = 1'b1, wake_go = 1'b0;
  logic [2:0] wake_sel = 3'h0;
  logic awready, wready, bvalid, arready, rvalid, crystal, cpu_run, stop_hold, osc_low;
  logic limp, bus_sel, mod_sel, mon_en, mon_rst, vco_rs, relock, irq;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd;
  logic [5:0] wk;
  int bad_count = 0, checked = 0, cyc = 0, n, c0, c1;
  int vco_cnt = 0, relock_cnt = 0, mrst_cnt = 0, hold_cnt = 0;

  slr_stop_recovery #(.check_count(chk)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .stop_exec(stop_exec), .wake_ext_reset(wk[0]), .wake_irq(wk[1]),
    .wake_nonmaskable_irq(wk[2]), .wake_key_port_j(wk[3]), .wake_key_port_h(wk[4]),
    .wake_can_controller(wk[5]), .crystal_present(crystal), .cpu_run(cpu_run),
    .stop_hold(stop_hold), .osc_reduced_amplitude(osc_low), .counter_from_vco(limp),
    .bus_clock_pll_select_out(bus_sel), .module_clock_select_out(mod_sel),
    .monitor_enable_out(mon_en), .monitor_reset_req(mon_rst), .vco_restart(vco_rs),
    .pll_relock_req(relock), .limp_home_irq(irq));

  slr_osc_wake_model osc (
    .aclk(aclk), .osc_enable(osc_enable), .wake_go(wake_go), .wake_sel(wake_sel),
    .crystal_present(crystal), .wake_ext_reset(wk[0]), .wake_irq(wk[1]),
    .wake_nonmaskable_irq(wk[2]), .wake_key_port_j(wk[3]), .wake_key_port_h(wk[4]),
    .wake_can_controller(wk[5]));

  initial forever #5 aclk = ~aclk;

  // Pulse counters, limp-cycle count and the run-time ceiling
  always @(posedge aclk)
  begin
    vco_cnt <= vco_cnt + int'(vco_rs);
    relock_cnt <= relock_cnt + int'(relock);
    mrst_cnt <= mrst_cnt + int'(mon_rst);
    hold_cnt <= hold_cnt + int'(limp);
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    if (bad_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd_reg(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rd_reg

  task automatic go_stop;
    while (wk !== 6'h00) @(posedge aclk);
    repeat (2) @(posedge aclk);
    stop_exec <= 1'b1;
    @(posedge aclk);
    stop_exec <= 1'b0;
    while (stop_hold !== 1'b1) @(posedge aclk);
  endtask : go_stop

  task automatic wake(input logic [2:0] s);
    wake_sel <= s;
    wake_go <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (cpu_run !== 1'b1);
    wake_go <= 1'b0;
  endtask : wake

  task automatic limp_exit(input logic [1:0] sel, input int relocks, input logic ie);
    osc_enable <= 1'b1;
    c0 = relock_cnt;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (limp !== 1'b0);
    `CHK(n <= 4 * chk + 50, 1'b1)
    `CHK({bus_sel, mod_sel}, sel)
    rd_reg(`SLR_OFS_STATUS);
    `CHK(rd[1:0], 2'b10)
    `CHK(relock_cnt - c0, relocks)
    `CHK(irq, ie)
    wr(`SLR_OFS_STATUS, 32'h0000_0002);
  endtask : limp_exit

  // Main sequence
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(`SLR_OFS_CONTROL);
    `CHK(rd[8:0], `SLR_CONTROL_RESET)
    rd_reg(12'h00c);
    `CHK(rs, `SLR_RESP_SLVERR)
    // Unmapped write refused and leaves the control word alone
    wr(12'h00c, 32'h0000_0001);
    `CHK(rs, `SLR_RESP_SLVERR)
    rd_reg(`SLR_OFS_CONTROL);
    `CHK(rd[8:0], `SLR_CONTROL_RESET)
    while (crystal !== 1'b1) @(posedge aclk);
    // Fast recovery on a good clock, every wake source
    wr(`SLR_OFS_CONTROL, 32'h0000_0002);
    `CHK(rs, `SLR_RESP_OKAY)
    for (int i = 0; i < 6; i++)
    begin
      go_stop();
      `CHK(mon_en, 1'b0)
      wake(3'(i));
      `CHK(n <= 8, 1'b1)
      `CHK(limp, 1'b0)
    end
    rd_reg(`SLR_OFS_STATUS);
    `CHK(rd[1:0], 2'b00)
    // Delayed pseudo-stop exit with the crystal kept, then lost
    for (int k = 1; k >= 0; k--)
    begin
      osc_enable <= k[0];
      wr(`SLR_OFS_CONTROL, 32'h0000_00d8);
      c0 = hold_cnt;
      go_stop();
      `CHK(osc_low, 1'b1)
      c1 = vco_cnt;
      wake(3'h2);
      `CHK(vco_cnt - c1, 1)
      `CHK(n >= 2 * chk && n <= 2 * chk + 14, 1'b1)
      `CHK(hold_cnt > c0, 1'b1)
      `CHK(limp, ~k[0])
      rd_reg(`SLR_OFS_STATUS);
      `CHK(rd[1:0], {~k[0], ~k[0]})
    end
    wr(`SLR_OFS_CONTROL, 32'h0000_0058);
    limp_exit(2'b00, 0, 1'b0);
    // Fast exit with no clock, interrupt on, PLL kept selected
    osc_enable <= 1'b0;
    wr(`SLR_OFS_CONTROL, 32'h0000_01e0);
    go_stop();
    wake(3'h5);
    `CHK({limp, bus_sel, mod_sel, mon_en}, 4'b1101)
    rd_reg(`SLR_OFS_STATUS);
    `CHK(rd[1:0], 2'b11)
    `CHK(irq, 1'b1)
    wr(`SLR_OFS_STATUS, 32'h0000_0002);
    rd_reg(`SLR_OFS_STATUS);
    `CHK(rd[1:0], 2'b01)
    `CHK(irq, 1'b0)
    limp_exit(2'b11, 1, 1'b1);
    // Crystal-only exit: short count, full count, slowed counter clock
    for (int j = 0; j < 3; j++)
    begin
      wr(`SLR_OFS_CONTROL, (j == 1) ? 32'h0000_0009 : 32'h0000_0001);
      wr(`SLR_OFS_SLOW, (j == 2) ? 32'h0000_0001 : 32'h0000_0000);
      c0 = hold_cnt;
      go_stop();
      wake(3'h3);
      c1 = ((j == 1) ? chk : 16) * ((j == 2) ? 4 : 2);
      `CHK(n >= c1 && n <= c1 + 14, 1'b1)
      `CHK(hold_cnt, c0)
    end
    // Stop with monitor on and no limp-home gives a monitor reset
    wr(`SLR_OFS_CONTROL, 32'h0000_0003);
    c0 = mrst_cnt;
    stop_exec <= 1'b1;
    @(posedge aclk);
    stop_exec <= 1'b0;
    repeat (6) @(posedge aclk);
    `CHK(mrst_cnt - c0, 1)
    print_verdict();
  end
endmodule : slr_stop_recovery_bench
